// file: pkg/dpsd_pkg.sv
// Constants and types for the drive panel status display
`default_nettype none
package dpsd_pkg;
	localparam int CLK_KHZ  = 200000;
	localparam int LONG_MS  = 1000;
	localparam int CONF_MS  = 2000;
	localparam int ANIM_MS  = 100;
	localparam int LONG_CYC = LONG_MS * CLK_KHZ;
	localparam int CONF_CYC = CONF_MS * CLK_KHZ;
	localparam int ANIM_CYC = ANIM_MS * CLK_KHZ;
	localparam int NKEY     = 4;
	localparam int K_MODE   = 0;
	localparam int K_WR     = 1;
	localparam int K_ADD    = 2;
	localparam int K_SUB    = 3;
	localparam logic [3:0] CODE_CTRL  = 4'h0;
	localparam logic [3:0] CODE_MAIN  = 4'h2;
	localparam logic [3:0] CODE_SETUP = 4'h4;
	localparam logic [3:0] CODE_SERVO = 4'h8;
	localparam logic [3:0] CODE_POLE  = 4'h9;
	localparam logic [2:0] GLYPH_LAST = 3'h6;
	localparam logic [2:0] KIND_NORM  = 3'h0;
	localparam logic [2:0] KIND_OTCW  = 3'h1;
	localparam logic [2:0] KIND_OTCCW = 3'h2;
	localparam logic [2:0] KIND_REGEN = 3'h3;
	localparam logic [2:0] KIND_OVLD  = 3'h4;
	localparam logic [2:0] KIND_ALARM = 3'h5;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h00;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h04;
	localparam logic [7:0] ADR_DISP     = 8'h08;
	localparam logic [7:0] ADR_CTRL     = 8'h0C;
	localparam logic [7:0] ADR_VERSION  = 8'h10;
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_WARN  = 1;
	localparam int IRQ_RSTOK = 2;
	localparam int IRQ_RSTNO = 3;
	localparam int NIRQ      = 4;
	localparam int CTRL_KEYEN = 0;
	localparam logic [3:0]  RST_MASK    = 4'h0;
	localparam logic [1:0]  RST_CTRL    = 2'h1;
	localparam logic [15:0] RST_VERSION = 16'h0000;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;
	typedef enum logic [4:0] {
		SC_STAT = 5'h01,
		SC_RST  = 5'h02,
		SC_CONF = 5'h04,
		SC_INFO = 5'h08,
		SC_VER  = 5'h10
	} dpsd_screen_t;
	typedef struct packed {
		logic ctrl_pwr;
		logic rdy;
		logic main_pwr;
		logic prep_done;
		logic pole_rdy;
		logic pole_busy;
		logic setup_done;
		logic servo_on;
		logic ot_cw;
		logic ot_ccw;
		logic regen_warn;
		logic ovld_warn;
		logic alarm;
		logic alarm_pwr_cycle;
	} dpsd_flags_t;
	typedef struct packed {
		dpsd_screen_t screen;
		logic [2:0]   kind;
		logic [3:0]   code;
		logic [7:0]   alarm_code;
		logic [2:0]   glyph;
		logic         blink;
		logic [15:0]  version;
	} dpsd_disp_t;
endpackage : dpsd_pkg
`default_nettype wire

// file: rtl/dpsd_top.sv
// Panel status display: keys, screens, animation and AXI4-Lite registers
//
// The address map and register access over AXI4-Lite were decided locally.
`default_nettype none
module dpsd_top
	import dpsd_pkg::*;
#(
	parameter int LONG_C = LONG_CYC,
	parameter int CONF_C = CONF_CYC,
	parameter int ANIM_C = ANIM_CYC
) (
	// Clock and reset
	input  wire  logic              clock,
	input  wire  logic              reset,
	// Front panel keys, high while pressed
	input  wire  logic [NKEY-1:0]   key_press,
	// Drive state
	input  wire  dpsd_flags_t       flags,
	input  wire  logic [7:0]        alarm_code,
	// Display, drive request and interrupt
	output var   dpsd_disp_t        disp,
	output logic                    alarm_reset_req,
	output logic                    irq,
	// AXI4-Lite slave
	input  wire  logic [7:0]        s_awaddr,
	input  wire  logic              s_awvalid,
	output logic                    s_awready,
	input  wire  logic [31:0]       s_wdata,
	input  wire  logic [3:0]        s_wstrb,
	input  wire  logic              s_wvalid,
	output logic                    s_wready,
	output logic [1:0]              s_bresp,
	output logic                    s_bvalid,
	input  wire  logic              s_bready,
	input  wire  logic [7:0]        s_araddr,
	input  wire  logic              s_arvalid,
	output logic                    s_arready,
	output logic [31:0]             s_rdata,
	output logic [1:0]              s_rresp,
	output logic                    s_rvalid,
	input  wire  logic              s_rready
);
	localparam logic [31:0] LONG_M1 = 32'(LONG_C - 1);
	localparam logic [31:0] CONF_M1 = 32'(CONF_C - 1);
	localparam logic [31:0] ANIM_M1 = 32'(ANIM_C - 1);

	// {animate, blink, code} for the drive state
	function automatic logic [5:0] stat_f(input dpsd_flags_t f);
		if (f.servo_on)
			return {2'b10, CODE_SERVO};
		else if (f.pole_busy)
			return {2'b10, CODE_POLE};
		else if (f.main_pwr && f.pole_rdy)
			return {2'b01, CODE_POLE};
		else if (f.setup_done)
			return {2'b00, CODE_SETUP};
		else if (f.main_pwr && !f.prep_done)
			return {2'b00, CODE_MAIN};
		return {2'b00, CODE_CTRL};
	endfunction : stat_f

	// Key synchronisers and hold counters
	logic        ks1_r [NKEY];
	logic        ks2_r [NKEY];
	logic        ks3_r [NKEY];
	logic        kst_r [NKEY];
	logic        kst_nxt [NKEY];
	logic        klg_r [NKEY];
	logic        klg_nxt [NKEY];
	logic [31:0] kh_r [NKEY];
	logic [31:0] kh_nxt [NKEY];
	logic [NKEY-1:0] k_long;
	logic [NKEY-1:0] k_short;
	logic        keys_en;

	for (genvar i = 0; i < NKEY; i++) begin : g_key
		always_comb begin
			kst_nxt[i] = kst_r[i];
			klg_nxt[i] = klg_r[i];
			kh_nxt[i]  = kh_r[i];
			k_long[i]  = 1'b0;
			k_short[i] = 1'b0;
			if (ks2_r[i] == ks3_r[i])
				kst_nxt[i] = ks3_r[i];
			if (kst_r[i]) begin
				if (!klg_r[i] && kh_r[i] == LONG_M1) begin
					k_long[i]  = keys_en;
					klg_nxt[i] = 1'b1;
				end else if (!klg_r[i]) begin
					kh_nxt[i] = kh_r[i] + 32'h1;
				end
				if (!kst_nxt[i])
					k_short[i] = keys_en && !klg_r[i];
			end else begin
				kh_nxt[i]  = 32'h0;
				klg_nxt[i] = 1'b0;
			end
		end
		always_ff @(posedge clock or posedge reset) begin
			if (reset) begin
				ks1_r[i] <= 1'b0;
				ks2_r[i] <= 1'b0;
				ks3_r[i] <= 1'b0;
				kst_r[i] <= 1'b0;
				klg_r[i] <= 1'b0;
				kh_r[i]  <= 32'h0;
			end else begin
				ks1_r[i] <= key_press[i];
				ks2_r[i] <= ks1_r[i];
				ks3_r[i] <= ks2_r[i];
				kst_r[i] <= kst_nxt[i];
				klg_r[i] <= klg_nxt[i];
				kh_r[i]  <= kh_nxt[i];
			end
		end
	end

	// Screens, animation and display
	dpsd_screen_t scr_r, scr_nxt;
	dpsd_disp_t   disp_r, disp_nxt;
	logic [31:0]  tmr_r, tmr_nxt;
	logic [31:0]  anim_r, anim_nxt;
	logic [3:0]   acode_r, acode_nxt;
	logic         alm_d_r, alm_d_nxt;
	logic         req_r, req_nxt;
	logic         ev_rstok, ev_rstno, ev_alarm, ev_warn;
	logic         warn_d_r, warn_d_nxt;
	logic         anim_on_r, anim_on_nxt;
	logic [5:0]   st;
	logic [15:0]  ver_r;

	always_comb begin
		scr_nxt    = scr_r;
		tmr_nxt    = tmr_r;
		anim_nxt   = (anim_r == ANIM_M1) ? 32'h0 : anim_r + 32'h1;
		acode_nxt  = acode_r;
		alm_d_nxt  = flags.alarm;
		warn_d_nxt = flags.regen_warn | flags.ovld_warn;
		req_nxt    = 1'b0;
		ev_rstok   = 1'b0;
		ev_rstno   = 1'b0;
		ev_alarm   = flags.alarm && !alm_d_r;
		ev_warn    = warn_d_nxt && !warn_d_r;
		st         = stat_f(flags);
		anim_on_nxt = st[5];
		if (ev_alarm)
			acode_nxt = disp_r.code;
		unique case (scr_r)
			SC_STAT: begin
				if (k_long[K_SUB])
					scr_nxt = SC_INFO;
				else if (flags.alarm && k_long[K_MODE])
					scr_nxt = SC_RST;
			end
			SC_RST: begin
				if (k_long[K_WR]) begin
					if (flags.alarm_pwr_cycle) begin
						ev_rstno = 1'b1;
						scr_nxt  = SC_STAT;
					end else begin
						ev_rstok = 1'b1;
						req_nxt  = 1'b1;
						tmr_nxt  = 32'h0;
						scr_nxt  = SC_CONF;
					end
				end else if (k_short[K_MODE]) begin
					scr_nxt = SC_STAT;
				end
			end
			SC_CONF: begin
				tmr_nxt = tmr_r + 32'h1;
				if (tmr_r == CONF_M1)
					scr_nxt = SC_STAT;
			end
			SC_INFO: begin
				if (k_long[K_WR])
					scr_nxt = SC_VER;
				else if (k_short[K_MODE])
					scr_nxt = SC_STAT;
			end
			SC_VER: begin
				if (k_short[K_MODE])
					scr_nxt = SC_INFO;
			end
		endcase
		disp_nxt            = disp_r;
		disp_nxt.screen     = scr_nxt;
		disp_nxt.version    = ver_r;
		disp_nxt.alarm_code = alarm_code;
		disp_nxt.blink      = st[4];
		disp_nxt.code       = flags.alarm ? acode_nxt : st[3:0];
		// Initial glyph on every start of an animation
		if (!st[5] || !anim_on_r || st[3:0] != disp_r.code)
			disp_nxt.glyph = 3'h0;
		else if (anim_r == ANIM_M1)
			disp_nxt.glyph = (disp_r.glyph == GLYPH_LAST) ? 3'h1 : disp_r.glyph + 3'h1;
		if (flags.alarm)
			disp_nxt.kind = KIND_ALARM;
		else if (flags.ot_cw)
			disp_nxt.kind = KIND_OTCW;
		else if (flags.ot_ccw)
			disp_nxt.kind = KIND_OTCCW;
		else if (flags.regen_warn)
			disp_nxt.kind = KIND_REGEN;
		else if (flags.ovld_warn)
			disp_nxt.kind = KIND_OVLD;
		else
			disp_nxt.kind = KIND_NORM;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			scr_r    <= SC_STAT;
			disp_r   <= '{screen: SC_STAT, default: '0};
			tmr_r    <= 32'h0;
			anim_r   <= 32'h0;
			acode_r  <= 4'h0;
			alm_d_r  <= 1'b0;
			warn_d_r <= 1'b0;
			anim_on_r <= 1'b0;
			req_r    <= 1'b0;
		end else begin
			scr_r    <= scr_nxt;
			disp_r   <= disp_nxt;
			tmr_r    <= tmr_nxt;
			anim_r   <= anim_nxt;
			acode_r  <= acode_nxt;
			alm_d_r  <= alm_d_nxt;
			warn_d_r <= warn_d_nxt;
			anim_on_r <= anim_on_nxt;
			req_r    <= req_nxt;
		end
	end

	// Register file and bus slave
	logic [NIRQ-1:0] ist_r, ist_nxt, msk_r, msk_nxt;
	logic [1:0]      ctl_r, ctl_nxt;
	logic [15:0]     ver_nxt;
	logic            irq_r, irq_nxt;
	logic            awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt;
	logic            arr_r, arr_nxt, rv_r, rv_nxt;
	logic [7:0]      aw_a_r, aw_a_nxt;
	logic [31:0]     wd_r, wd_nxt, rd_r, rd_nxt;
	logic [3:0]      ws_r, ws_nxt;
	logic [1:0]      br_r, br_nxt, rr_r, rr_nxt;
	logic            do_wr, rd_hs;

	function automatic logic [31:0] wmask_f(input logic [31:0] old, input logic [31:0] d,
	                                        input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		return r;
	endfunction : wmask_f

	assign keys_en = ctl_r[CTRL_KEYEN];

	always_comb begin
		awr_nxt  = awr_r;
		wr_nxt   = wr_r;
		bv_nxt   = bv_r;
		br_nxt   = br_r;
		aw_a_nxt = aw_a_r;
		wd_nxt   = wd_r;
		ws_nxt   = ws_r;
		arr_nxt  = arr_r;
		rv_nxt   = rv_r;
		rd_nxt   = rd_r;
		rr_nxt   = rr_r;
		msk_nxt  = msk_r;
		ctl_nxt  = ctl_r;
		ver_nxt  = ver_r;
		ist_nxt  = ist_r;
		if (s_awvalid && awr_r) begin
			awr_nxt  = 1'b0;
			aw_a_nxt = s_awaddr;
		end
		if (s_wvalid && wr_r) begin
			wr_nxt = 1'b0;
			wd_nxt = s_wdata;
			ws_nxt = s_wstrb;
		end
		do_wr = !awr_r && !wr_r && !bv_r;
		if (do_wr) begin
			bv_nxt = 1'b1;
			br_nxt = RESP_OK;
			case (aw_a_r)
				ADR_IRQ_MASK: msk_nxt = NIRQ'(wmask_f(32'(msk_r), wd_r, ws_r));
				ADR_CTRL:     ctl_nxt = 2'(wmask_f(32'(ctl_r), wd_r, ws_r));
				ADR_VERSION:  ver_nxt = 16'(wmask_f(32'(ver_r), wd_r, ws_r));
				ADR_IRQ_STAT, ADR_DISP: br_nxt = RESP_OK;
				default:      br_nxt = RESP_ERR;
			endcase
		end
		if (bv_r && s_bready) begin
			bv_nxt  = 1'b0;
			awr_nxt = 1'b1;
			wr_nxt  = 1'b1;
		end
		rd_hs = s_arvalid && arr_r;
		if (rd_hs) begin
			arr_nxt = 1'b0;
			rv_nxt  = 1'b1;
			rr_nxt  = RESP_OK;
			case (s_araddr)
				ADR_IRQ_STAT: begin
					rd_nxt  = 32'(ist_r);
					ist_nxt = '0;
				end
				ADR_IRQ_MASK: rd_nxt = 32'(msk_r);
				ADR_DISP:     rd_nxt = {disp_r.alarm_code, 3'h0, disp_r.screen,
				                        disp_r.kind, disp_r.blink, disp_r.glyph,
				                        1'b0, acode_r, disp_r.code};
				ADR_CTRL:     rd_nxt = 32'(ctl_r);
				ADR_VERSION:  rd_nxt = 32'(ver_r);
				default: begin
					rd_nxt = 32'h0;
					rr_nxt = RESP_ERR;
				end
			endcase
		end
		if (rv_r && s_rready) begin
			rv_nxt  = 1'b0;
			arr_nxt = 1'b1;
		end
		// Hardware set wins over read clear
		ist_nxt[IRQ_ALARM] = ist_nxt[IRQ_ALARM] | ev_alarm;
		ist_nxt[IRQ_WARN]  = ist_nxt[IRQ_WARN]  | ev_warn;
		ist_nxt[IRQ_RSTOK] = ist_nxt[IRQ_RSTOK] | ev_rstok;
		ist_nxt[IRQ_RSTNO] = ist_nxt[IRQ_RSTNO] | ev_rstno;
		irq_nxt = |(ist_nxt & msk_nxt);
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			awr_r  <= 1'b1;
			wr_r   <= 1'b1;
			bv_r   <= 1'b0;
			br_r   <= RESP_OK;
			aw_a_r <= 8'h00;
			wd_r   <= 32'h0;
			ws_r   <= 4'h0;
			arr_r  <= 1'b1;
			rv_r   <= 1'b0;
			rd_r   <= 32'h0;
			rr_r   <= RESP_OK;
			ist_r  <= '0;
			msk_r  <= RST_MASK;
			ctl_r  <= RST_CTRL;
			ver_r  <= RST_VERSION;
			irq_r  <= 1'b0;
		end else begin
			awr_r  <= awr_nxt;
			wr_r   <= wr_nxt;
			bv_r   <= bv_nxt;
			br_r   <= br_nxt;
			aw_a_r <= aw_a_nxt;
			wd_r   <= wd_nxt;
			ws_r   <= ws_nxt;
			arr_r  <= arr_nxt;
			rv_r   <= rv_nxt;
			rd_r   <= rd_nxt;
			rr_r   <= rr_nxt;
			ist_r  <= ist_nxt;
			msk_r  <= msk_nxt;
			ctl_r  <= ctl_nxt;
			ver_r  <= ver_nxt;
			irq_r  <= irq_nxt;
		end
	end

	assign disp            = disp_r;
	assign alarm_reset_req = req_r;
	assign irq             = irq_r;
	assign s_awready       = awr_r;
	assign s_wready        = wr_r;
	assign s_bvalid        = bv_r;
	assign s_bresp         = br_r;
	assign s_arready       = arr_r;
	assign s_rvalid        = rv_r;
	assign s_rdata         = rd_r;
	assign s_rresp         = rr_r;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_rst_scr;
		scr_r == SC_RST && k_long[K_WR];
	endsequence
	AST_CODE0: assert property (flags.ctrl_pwr && flags.rdy && !flags.main_pwr
		&& !flags.setup_done && !flags.pole_busy && !flags.servo_on && !flags.alarm
		|=> disp.code == CODE_CTRL) else $error("code 0 missing");
	AST_CODE2: assert property (flags.main_pwr && !flags.prep_done && !flags.setup_done
		&& !flags.pole_rdy && !flags.pole_busy && !flags.servo_on && !flags.alarm
		|=> disp.code == CODE_MAIN) else $error("code 2 missing");
	AST_CODE9B: assert property (flags.main_pwr && flags.pole_rdy && !flags.pole_busy
		&& !flags.servo_on && !flags.alarm
		|=> disp.code == CODE_POLE && disp.blink) else $error("blinking 9 missing");
	AST_GLYPH0: assert property ($rose(flags.pole_busy) && !flags.servo_on
		&& !flags.alarm |=> disp.glyph == 3'h0) else $error("initial glyph missing");
	AST_GLYPH8: assert property ($rose(flags.servo_on) && !flags.alarm
		|=> disp.glyph == 3'h0) else $error("servo initial glyph missing");
	AST_CODE4: assert property (flags.setup_done && !flags.pole_rdy && !flags.pole_busy
		&& !flags.servo_on && !flags.alarm
		|=> disp.code == CODE_SETUP && !disp.blink) else $error("steady 4 missing");
	AST_CODE8: assert property (flags.servo_on && !flags.alarm
		|=> disp.code == CODE_SERVO && !disp.blink) else $error("code 8 missing");
	AST_OTCW: assert property (!flags.alarm && flags.ot_cw
		|=> disp.kind == KIND_OTCW) else $error("cw over-travel missing");
	AST_OT: assert property (!flags.alarm && flags.ot_ccw && !flags.ot_cw
		|=> disp.kind == KIND_OTCCW) else $error("ccw over-travel missing");
	AST_REGEN: assert property (!flags.alarm && !flags.ot_cw && !flags.ot_ccw
		&& flags.regen_warn |=> disp.kind == KIND_REGEN) else $error("regen warning missing");
	AST_OVLD: assert property (!flags.alarm && !flags.ot_cw && !flags.ot_ccw
		&& !flags.regen_warn && flags.ovld_warn
		|=> disp.kind == KIND_OVLD) else $error("overload warning missing");
	AST_ALARM: assert property ($rose(flags.alarm)
		|=> disp.kind == KIND_ALARM && disp.code == $past(disp.code))
		else $error("alarm status code lost");
	AST_REFUSE: assert property (s_rst_scr ##0 flags.alarm_pwr_cycle
		|=> !alarm_reset_req && scr_r == SC_STAT) else $error("power-cycle alarm cleared");
	AST_RESET: assert property (s_rst_scr ##0 !flags.alarm_pwr_cycle
		|=> alarm_reset_req ##1 !alarm_reset_req && scr_r == SC_CONF)
		else $error("reset request wrong");
	AST_VERBACK: assert property (scr_r == SC_VER && k_short[K_MODE]
		|=> scr_r == SC_INFO && disp.screen == SC_INFO) else $error("version exit wrong");
	AST_INFO: assert property (scr_r == SC_STAT && k_long[K_SUB]
		|=> scr_r == SC_INFO) else $error("info menu not opened");
	AST_LONG: assert property (k_long[K_MODE]
		|-> kh_r[K_MODE] == LONG_M1 && kst_r[K_MODE]) else $error("long press early");
endmodule : dpsd_top
`default_nettype wire

// file: verif/dpsd_operator.sv
// Operator model pressing the front-panel keys
`default_nettype none
module dpsd_operator
	import dpsd_pkg::*;
(
	// Clock
	input  wire logic        clock,
	// Keys, high while pressed
	output logic [NKEY-1:0]  key_press
);
	timeunit 1ns;
	timeprecision 100ps;

	initial key_press = '0;

	// Press one key for n cycles, then let the panel settle
	task automatic hold(input int k, input int n);
		@(posedge clock);
		key_press[k] <= 1'h1;
		repeat (n) @(posedge clock);
		key_press[k] <= 1'h0;
		repeat (8) @(posedge clock);
		#1;
	endtask : hold

	task automatic down(input int k);
		@(posedge clock);
		key_press[k] <= 1'h1;
	endtask : down

	task automatic up(input int k);
		@(posedge clock);
		key_press[k] <= 1'h0;
	endtask : up
endmodule : dpsd_operator
`default_nettype wire

// file: verif/dpsd_top_tb.sv
// Self-checking bench for the panel status display
`default_nettype none
module drive_panel_status_display_tb
	import dpsd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int LONG_T = 20;
	localparam int CONF_T = 40;
	localparam int ANIM_T = 4;
	localparam int LIMIT  = 20000;
	localparam logic [13:0] ST_FLAGS [6] = '{14'h3000, 14'h3800, 14'h3A00, 14'h3D00,
		14'h3C80, 14'h3CC0};
	localparam logic [3:0]  ST_CODE [6]  = '{CODE_CTRL, CODE_MAIN, CODE_POLE, CODE_POLE,
		CODE_SETUP, CODE_SERVO};
	localparam logic [5:0]  ST_BLINK     = 6'h04;
	localparam logic [5:0]  ST_ANIM      = 6'h28;
	localparam logic [13:0] KD_FLAGS [4] = '{14'h3CE0, 14'h3CD0, 14'h3CC8, 14'h3CC4};

	logic            clock;
	logic            reset;
	logic [NKEY-1:0] key_press;
	dpsd_flags_t     flags;
	logic [7:0]      alarm_code;
	dpsd_disp_t      disp;
	logic            alarm_reset_req;
	logic            irq;
	logic [7:0]      s_awaddr, s_araddr;
	logic            s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic            s_arvalid, s_arready, s_rvalid, s_rready;
	logic [31:0]     s_wdata, s_rdata, rd;
	logic [3:0]      s_wstrb;
	logic [1:0]      s_bresp, s_rresp, rsp;
	int              num_errors, cmp_count, cycles, req_cnt;

	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end

	dpsd_top #(.LONG_C(LONG_T), .CONF_C(CONF_T), .ANIM_C(ANIM_T)) dut (
		.clock(clock), .reset(reset), .key_press(key_press), .flags(flags),
		.alarm_code(alarm_code), .disp(disp), .alarm_reset_req(alarm_reset_req), .irq(irq),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready)
	);

	dpsd_operator op (.clock(clock), .key_press(key_press));

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_t, w_t, b_t;
		@(posedge clock);
		s_awaddr  <= a;
		s_wdata   <= d;
		s_wstrb   <= 4'hF;
		s_awvalid <= 1'h1;
		s_wvalid  <= 1'h1;
		s_bready  <= 1'h1;
		b_t = 1'h0;
		while (b_t !== 1'h1) begin
			#1;
			aw_t = s_awvalid & s_awready;
			w_t  = s_wvalid & s_wready;
			b_t  = s_bready & s_bvalid;
			r    = s_bresp;
			@(posedge clock);
			if (aw_t)
				s_awvalid <= 1'h0;
			if (w_t)
				s_wvalid <= 1'h0;
			if (b_t)
				s_bready <= 1'h0;
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_t, r_t;
		@(posedge clock);
		s_araddr  <= a;
		s_arvalid <= 1'h1;
		s_rready  <= 1'h1;
		r_t = 1'h0;
		while (r_t !== 1'h1) begin
			#1;
			ar_t = s_arvalid & s_arready;
			r_t  = s_rready & s_rvalid;
			d    = s_rdata;
			r    = s_rresp;
			@(posedge clock);
			if (ar_t)
				s_arvalid <= 1'h0;
			if (r_t)
				s_rready <= 1'h0;
		end
	endtask : axi_rd

	// Cycle limit and reset-request pulse count
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (alarm_reset_req === 1'h1)
			req_cnt <= req_cnt + 1;
		if (cycles == LIMIT) begin
			num_errors++;
			finish_test();
		end
	end

	initial begin
		{num_errors, cmp_count, cycles, req_cnt} = '0;
		reset = 1'h1;
		flags = '0;
		alarm_code = 8'h00;
		{s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
		{s_araddr, s_arvalid, s_rready} = '0;
		repeat (2) @(posedge clock);
		reset <= 1'h0;

		axi_rd(ADR_IRQ_MASK, rd, rsp);
		chk(rd, 32'h0);
		axi_rd(ADR_CTRL, rd, rsp);
		chk(rd, 32'h1);
		axi_rd(ADR_VERSION, rd, rsp);
		chk(rd, 32'h0);
		axi_rd(8'h20, rd, rsp);
		chk(rd, 32'h0);
		chk(rsp, RESP_ERR);
		axi_wr(8'h24, 32'h1, rsp);
		chk(rsp, RESP_ERR);
		axi_wr(ADR_VERSION, 32'h1234, rsp);
		chk(rsp, RESP_OK);
		axi_rd(ADR_VERSION, rd, rsp);
		chk(rd, 32'h1234);
		$display("test registers done");

		for (int i = 0; i < 6; i++) begin
			@(posedge clock);
			flags <= dpsd_flags_t'(ST_FLAGS[i]);
			tick(1);
			chk(disp.code, ST_CODE[i]);
			chk(disp.blink, ST_BLINK[i]);
			chk(disp.glyph, 32'h0);
			if (ST_ANIM[i]) begin
				tick(3 * ANIM_T);
				chk(disp.code, ST_CODE[i]);
				chk(disp.glyph != 3'h0 && disp.glyph <= GLYPH_LAST, 1'h1);
			end
		end
		$display("test status codes done");

		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			flags <= dpsd_flags_t'(KD_FLAGS[i]);
			tick(2);
			chk(disp.kind, i + 1);
		end
		chk(irq, 1'h0);
		axi_rd(ADR_IRQ_STAT, rd, rsp);
		chk(rd, 32'h2);
		axi_rd(ADR_IRQ_STAT, rd, rsp);
		chk(rd, 32'h0);
		$display("test warnings done");

		axi_wr(ADR_IRQ_MASK, 32'hF, rsp);
		@(posedge clock);
		flags <= dpsd_flags_t'(14'h3CC2);
		alarm_code <= 8'h5A;
		tick(3);
		chk(disp.kind, KIND_ALARM);
		chk(disp.alarm_code, 8'h5A);
		chk(irq, 1'h1);
		@(posedge clock);
		flags <= dpsd_flags_t'(14'h3C82);
		tick(3);
		chk(disp.code, CODE_SERVO);
		$display("test alarm display done");

		op.hold(K_MODE, 6);
		chk(disp.screen, SC_STAT);
		op.hold(K_MODE, LONG_T + 8);
		chk(disp.screen, SC_RST);
		op.down(K_WR);
		for (int n = 0; n < 60 && disp.screen !== SC_CONF; n++)
			tick(1);
		chk(disp.screen, SC_CONF);
		tick(CONF_T - 4);
		chk(disp.screen, SC_CONF);
		chk(req_cnt, 1);
		op.up(K_WR);
		flags <= dpsd_flags_t'(14'h3CC0);
		tick(8);
		chk(disp.screen, SC_STAT);
		chk(disp.kind, KIND_NORM);
		axi_rd(ADR_IRQ_STAT, rd, rsp);
		chk(rd, 32'h5);
		$display("test alarm reset done");

		@(posedge clock);
		flags <= dpsd_flags_t'(14'h3CC3);
		op.hold(K_MODE, LONG_T + 8);
		chk(disp.screen, SC_RST);
		op.hold(K_WR, LONG_T + 8);
		chk(disp.screen, SC_STAT);
		chk(req_cnt, 1);
		chk(disp.kind, KIND_ALARM);
		axi_rd(ADR_IRQ_STAT, rd, rsp);
		chk(rd, 32'h9);
		$display("test refused reset done");

		op.hold(K_SUB, LONG_T + 8);
		chk(disp.screen, SC_INFO);
		op.hold(K_WR, LONG_T + 8);
		chk(disp.screen, SC_VER);
		chk(disp.version, 16'h1234);
		op.hold(K_MODE, 6);
		chk(disp.screen, SC_INFO);
		op.hold(K_MODE, 6);
		chk(disp.screen, SC_STAT);
		chk(disp.kind, KIND_ALARM);
		$display("test version menu done");

		axi_wr(ADR_CTRL, 32'h0, rsp);
		chk(rsp, RESP_OK);
		op.hold(K_SUB, LONG_T + 8);
		chk(disp.screen, SC_STAT);
		axi_wr(ADR_DISP, 32'hFFFFFFFF, rsp);
		chk(rsp, RESP_OK);
		axi_rd(ADR_DISP, rd, rsp);
		chk(rd & 32'hFFFFF1FF, {8'h5A, 3'h0, SC_STAT, KIND_ALARM, 4'h0, 1'h0,
			CODE_SERVO, CODE_SERVO});
		$display("test key enable and display register done");
		finish_test();
	end
endmodule : drive_panel_status_display_tb
`default_nettype wire
